//--- dv/rbd_cmd_properties.sv
// Concurrent checks on the ports of the raw block command decoder.
// Assumes clock enable held high and one command in flight at a time.
`timescale 1ns/1ns
module rbd_cmd_properties (
    input wire logic clk, nrst, cmd_valid, cmd_ready, sts_valid, sts_check,
    input wire logic tx_valid, tx_ready, rx_valid, rx_ready, med_req,
    input wire logic med_physical_address_flag, med_ack, med_prev_ok, med_done,
    input wire logic med_wr_valid, med_wr_ready, med_wr_last,
    input wire logic [7:0] cmd_opcode, tx_data, rx_data, med_wr_data,
    input wire logic [7:0] med_head, med_sector,
    input wire logic [15:0] cmd_len, med_cyl,
    input wire logic [31:0] med_lba,
    input wire logic [3:0] sts_sense_key,
    input wire logic [1:0] med_op
);
    logic take, txh, wrh;
    logic [7:0] last_op;
    logic [15:0] alloc, tx_cnt, wr_cnt;
    logic [79:0] hsh;
    assign take = cmd_valid && cmd_ready;
    assign txh = tx_valid && tx_ready;
    assign wrh = med_wr_valid && med_wr_ready;
    // Per-command counters, restarted at every accepted command.
    always_ff @(posedge clk)
    begin
        if (!nrst || take)
        begin
            last_op <= nrst ? cmd_opcode : 8'h00;
            alloc <= cmd_len;
            tx_cnt <= 16'h0000;
            wr_cnt <= 16'h0000;
            hsh <= 80'h02142006420080060000;
        end
        else
        begin
            tx_cnt <= tx_cnt + 16'(txh);
            wr_cnt <= wr_cnt + 16'(wrh);
            hsh <= txh ? hsh << 8 : hsh;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_req_follow: assert property (
        take && (cmd_opcode inside {8'hF0, 8'hEE, 8'hED} ||
        cmd_opcode == 8'hFC && cmd_len == 16'h020C) |=> med_req)
        else $error("media request missing");
    chk_len_refused: assert property (
        take && cmd_opcode == 8'hFC && cmd_len != 16'h020C |-> ##2
        sts_valid && sts_check && sts_sense_key == 4'h5)
        else $error("bad length not refused");
    chk_track_sector: assert property (
        med_req && med_op inside {2'h1, 2'h2} |->
        med_sector == 8'h00 && (med_op == 2'h1 || med_physical_address_flag))
        else $error("track request fields wrong");
    chk_addr_split: assert property (
        med_req |-> {med_cyl, med_head} == med_lba[31:8])
        else $error("cylinder or head wrong");
    chk_prev_bad: assert property (
        last_op inside {8'hF0, 8'hFC} && med_ack && !med_prev_ok |->
        ##[1:4] sts_valid && sts_check && sts_sense_key == 4'h3)
        else $error("unreadable header not reported");
    chk_alloc_bound: assert property (
        txh |-> tx_cnt < alloc)
        else $error("byte beyond allocation");
    chk_header_bytes: assert property (
        txh && last_op == 8'hF0 && tx_cnt < 16'h000A |-> tx_data == hsh[79:72])
        else $error("descriptive header byte wrong");
    chk_wr_pass: assert property (
        rx_valid && rx_ready |=>
        med_wr_valid && med_wr_data == $past(rx_data))
        else $error("write byte not passed on");
    chk_wr_last: assert property (
        wrh |-> med_wr_last == (wr_cnt == 16'h020B))
        else $error("last write byte misplaced");
    chk_done_good: assert property (
        last_op inside {8'hED, 8'hFC} && med_done |->
        ##[1:3] sts_valid && !sts_check)
        else $error("good status missing");
    cover property (take && cmd_opcode == 8'hFC);
    cover property (txh && tx_cnt == alloc - 16'h0001);
    cover property (med_ack && !med_prev_ok);
endmodule

//--- dv/rbd_media_model.sv
// Behavioural media read/write path facing the command decoder.
// Assumes one request at a time; it answers after one seek cycle.
`timescale 1ns/1ns
module rbd_media_model (
    input wire logic clk, nrst, slow, ok, med_req, med_rd_ready,
    input wire logic med_wr_valid, med_wr_last,
    input wire logic [1:0] med_op,
    output logic med_ack, med_prev_ok, med_done, med_rd_valid, med_rd_last,
    output logic med_wr_ready,
    output logic [7:0] med_rd_data
);
    logic [1:0] op;
    logic [9:0] n, len;
    logic run, dly, t, wl;
    // Seek, then ack or done; then stream a block or a track of headers.
    always_ff @(posedge clk)
    begin
        med_ack <= 1'h0;
        // Done trails the last byte by two cycles so the decoder is waiting.
        wl <= med_wr_valid && med_wr_ready && med_wr_last;
        med_done <= wl;
        t <= nrst && !t;
        if (!nrst)
        begin
            run <= 1'h0;
            dly <= 1'h0;
        end
        else if (med_req)
        begin
            op <= med_op;
            dly <= 1'h1;
            n <= 10'h000;
            len <= med_op == 2'h0 ? 10'h20C : 10'h018;
        end
        else if (dly)
        begin
            dly <= 1'h0;
            med_ack <= op != 2'h2;
            med_prev_ok <= ok;
            med_done <= op == 2'h2;
            run <= op == 2'h1 || op == 2'h0 && ok;
        end
        else if (med_rd_valid && med_rd_ready)
        begin
            n <= n + 10'h001;
            run <= n != len - 10'h001;
        end
    end
    // Slow mode stalls every other cycle; idle data is not the last byte.
    assign med_rd_valid = run && !(slow && t);
    assign med_rd_last = med_rd_valid && n == len - 10'h001;
    assign med_rd_data = med_rd_valid ? n[7:0] : ~n[7:0];
    assign med_wr_ready = !(slow && t);
endmodule

//--- dv/tb_raw_block_diag_commands.sv
// Self-checking bench for the raw block command decoder.
// Assumes the media model and the property checker beside it.
`timescale 1ns/1ns
module tb_raw_block_diag_commands;
    typedef struct packed {
        logic [7:0] op;
        logic ph, ok, ck;
        logic [15:0] len, n;
        logic [3:0] key;
    } rbd_row_t;
    rbd_row_t rows [11] = '{
        '{8'hF0, 1'h1, 1'h1, 1'h0, 16'h0224, 16'h0216, 4'h0},
        '{8'hF0, 1'h0, 1'h1, 1'h0, 16'h0005, 16'h0005, 4'h0},
        '{8'hF0, 1'h1, 1'h0, 1'h1, 16'h0224, 16'h0000, 4'h3},
        '{8'hEE, 1'h1, 1'h0, 1'h0, 16'h0064, 16'h0018, 4'h0},
        '{8'hEE, 1'h0, 1'h1, 1'h0, 16'h0000, 16'h0000, 4'h0},
        '{8'hED, 1'h1, 1'h1, 1'h0, 16'h0000, 16'h0000, 4'h0},
        '{8'hFC, 1'h1, 1'h1, 1'h0, 16'h020C, 16'h020C, 4'h0},
        '{8'hFC, 1'h0, 1'h1, 1'h0, 16'h020C, 16'h020C, 4'h0},
        '{8'hFC, 1'h1, 1'h1, 1'h1, 16'h020B, 16'h0000, 4'h5},
        '{8'hFC, 1'h1, 1'h0, 1'h1, 16'h020C, 16'h0000, 4'h3},
        '{8'h12, 1'h0, 1'h1, 1'h1, 16'h0000, 16'h0000, 4'h5}};
    logic clk = 0, nrst = 0, cmd_valid = 0, ph = 0, tx_ready = 1;
    logic rx_valid = 0, slow = 0, ok = 1;
    logic [7:0] op = 8'h00, rx_data = 8'h00;
    logic [15:0] len = 16'h0000, ntx = 16'h0000, k = 16'h0000;
    logic cmd_ready, sts_valid, sts_check, tx_valid, rx_ready, med_req;
    logic med_physical_address_flag, med_ack, med_prev_ok, med_done, med_rd_valid;
    logic med_rd_ready, med_rd_last, med_wr_valid, med_wr_ready, med_wr_last;
    logic [7:0] tx_data, med_head, med_sector, med_rd_data, med_wr_data;
    logic [3:0] sts_sense_key;
    logic [1:0] med_op;
    logic [15:0] med_cyl;
    logic [31:0] med_lba;
    int fails = 0, checked = 0, cyc = 0;
    rbd_cmd u_dut (.ce(1'h1), .cmd_addr(32'h12345607), .cmd_opcode(op),
        .physical_address_flag(ph), .cmd_len(len), .clk, .nrst, .cmd_valid,
        .cmd_ready, .sts_valid, .sts_check, .sts_sense_key, .tx_valid,
        .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .med_req, .med_op,
        .med_physical_address_flag, .med_lba, .med_cyl, .med_head, .med_sector, .med_ack,
        .med_prev_ok, .med_done, .med_rd_valid, .med_rd_ready, .med_rd_data,
        .med_rd_last, .med_wr_valid, .med_wr_ready, .med_wr_data,
        .med_wr_last);
    rbd_media_model u_media (.clk, .nrst, .slow, .ok, .med_req, .med_op,
        .med_ack, .med_prev_ok, .med_done, .med_rd_valid, .med_rd_ready,
        .med_rd_data, .med_rd_last, .med_wr_valid, .med_wr_ready,
        .med_wr_last);
    always #20 clk = ~clk;
    task automatic chk(input string nm, input logic [15:0] s, e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Expected image: descriptive header for full reads, then media bytes.
    function automatic logic [7:0] exp_byte(input logic [15:0] i);
        logic [79:0] h;
        h = 80'h02142006420080060000 << (8 * i);
        if (op != 8'hF0)
            return i[7:0];
        return i < 16'h000A ? h[79:72] : 8'(i - 16'h000A);
    endfunction
    // Scoring just before the edge that takes each byte; run ceiling.
    always @(negedge clk)
    begin
        if (tx_valid === 1'h1 && tx_ready === 1'h1)
        begin
            chk("tx_data", 16'(tx_data), 16'(exp_byte(ntx)));
            ntx++;
        end
        if (rx_valid && rx_ready === 1'h1)
            k++;
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            close_out();
        end
    end
    always @(posedge clk)
        #1 rx_data = k[7:0] ^ 8'hA5;
    // One command from offer to status; writes send the whole block.
    task automatic run(input rbd_row_t r);
        int w;
        op = r.op;
        ph = r.ph;
        ok = r.ok;
        len = r.len;
        ntx = 16'h0000;
        k = 16'h0000;
        cmd_valid = 1'h1;
        rx_valid = r.op == 8'hFC;
        @(negedge clk);
        while (cmd_ready !== 1'h1)
            @(negedge clk);
        @(posedge clk);
        #1 cmd_valid = 1'h0;
        w = 0;
        while (sts_valid !== 1'h1 && w < 4000)
        begin
            @(negedge clk);
            w++;
        end
        chk("check", 16'(sts_check), 16'(r.ck));
        chk("key", 16'(sts_sense_key), 16'(r.key));
        chk("count", r.op == 8'hFC ? k : ntx, r.n);
        @(posedge clk);
        #1;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        #1 nrst = 1'h1;
        chk("idle", {cmd_ready, sts_valid, tx_valid, med_req}, 16'h0008);
        for (int i = 0; i < 11; i++)
            run(rows[i]);
        // Initiator stalls while the media is slow: the buffer must fill.
        tx_ready = 1'h0;
        slow = 1'h1;
        fork
            run(rows[0]);
            begin
                repeat (150) @(posedge clk);
                #1 chk("full", {med_rd_ready, tx_valid}, 16'h0001);
                tx_ready = 1'h1;
            end
        join
        close_out();
    end
endmodule
bind rbd_cmd rbd_cmd_properties u_props (.clk, .nrst, .cmd_valid,
    .cmd_ready, .sts_valid, .sts_check, .tx_valid, .tx_ready, .rx_valid,
    .rx_ready, .med_req, .med_physical_address_flag, .med_ack, .med_prev_ok, .med_done,
    .med_wr_valid, .med_wr_ready, .med_wr_last, .cmd_opcode, .tx_data,
    .rx_data, .med_wr_data, .med_head, .med_sector, .cmd_len, .med_cyl,
    .med_lba, .sts_sense_key, .med_op);

//--- hw/rbd_cmd.sv
// Decoder and data formatter for the raw block diagnostic commands.
// Assumes decoded CDB fields in, and a media path with ack/stream/done.
//
// What this block does
// - Ten-byte header precedes raw block image.
// - Raw read data cut at allocation length.
// - Block is 524 bytes: 6+512+6.
// - Total length counts eight bytes plus block.
// - Total length unchanged when data truncated.
// - Descriptors 001, 010, 100, end 000.
// - Field length gives bytes of its field.
// - End mark field length is zero.
// - Raw data returned uncorrected, as read.
// - Read headers returns requested header bytes.
// - Header data always starts at sector 0.
// - Physical headers: cylinder, head, sector ignored.
// - Logical headers address is a block address.
// - Zero allocation seeks, reads, sends nothing.
// - Reformat takes cylinder and head, formats.
// - Raw write uses initiator's exact bytes.
// - Raw write needs readable previous header.
// - Logical raw write: checks, first block.
// - Physical raw write: cylinder, head, sector.
// - Raw write length must be 524.
`timescale 1ns/1ns
module rbd_cmd (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic physical_address_flag,
    input wire logic [31:0] cmd_addr,
    input wire logic [15:0] cmd_len,
    output logic sts_valid,
    output logic sts_check,
    output logic [3:0] sts_sense_key,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    output logic med_req,
    output logic [1:0] med_op,
    output logic med_physical_address_flag,
    output logic [31:0] med_lba,
    output logic [15:0] med_cyl,
    output logic [7:0] med_head,
    output logic [7:0] med_sector,
    input wire logic med_ack,
    input wire logic med_prev_ok,
    input wire logic med_done,
    input wire logic med_rd_valid,
    output logic med_rd_ready,
    input wire logic [7:0] med_rd_data,
    input wire logic med_rd_last,
    output logic med_wr_valid,
    input wire logic med_wr_ready,
    output logic [7:0] med_wr_data,
    output logic med_wr_last
);
    rbd_pkg::rbd_state_t state;
    rbd_pkg::rbd_state_t next_state;
    logic [7:0] op;
    logic [15:0] alloc;
    logic [15:0] sent_cnt;
    logic [15:0] wr_cnt;
    logic [3:0] hdr_idx;
    logic [7:0] hdr_byte;
    logic keep, fifo_in_valid, fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic rd_take, wr_full, rx_take, wr_pop, fail_check;
    logic [3:0] fail_key;

    // ----------------------------------------------------------------
    // Descriptive header bytes
    // ----------------------------------------------------------------
    // Built from constants so the figures cannot drift from the block shape.
    always_comb
    begin
        case (hdr_idx)
            4'h0: hdr_byte = rbd_pkg::TOTAL_AVAIL[15:8];
            4'h1: hdr_byte = rbd_pkg::TOTAL_AVAIL[7:0];
            4'h2: hdr_byte = {rbd_pkg::FD_BLOCK_HDR,
                              rbd_pkg::HDR_FIELD_LEN[12:8]};
            4'h3: hdr_byte = rbd_pkg::HDR_FIELD_LEN[7:0];
            4'h4: hdr_byte = {rbd_pkg::FD_USER_DATA,
                              rbd_pkg::DATA_FIELD_LEN[12:8]};
            4'h5: hdr_byte = rbd_pkg::DATA_FIELD_LEN[7:0];
            4'h6: hdr_byte = {rbd_pkg::FD_ECC,
                              rbd_pkg::ECC_FIELD_LEN[12:8]};
            4'h7: hdr_byte = rbd_pkg::ECC_FIELD_LEN[7:0];
            4'h8: hdr_byte = {rbd_pkg::FD_END, 5'h00};
            4'h9: hdr_byte = 8'h00;
            default: hdr_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Data path into the FIFO
    // ----------------------------------------------------------------
    // Bytes past the allocation are drained from the media but dropped.
    assign keep = sent_cnt < alloc;
    assign fifo_in_valid = ce && ((state == rbd_pkg::RBD_HDR && keep)
        || (state == rbd_pkg::RBD_STREAM && med_rd_valid && keep));
    assign fifo_in_data = (state == rbd_pkg::RBD_HDR) ? hdr_byte
        : med_rd_data;
    assign med_rd_ready = ce && (state == rbd_pkg::RBD_STREAM)
        && (fifo_in_ready || !keep);
    assign rd_take = med_rd_valid && med_rd_ready;

    rbd_fifo #(
        .WIDTH(rbd_pkg::FIFO_WIDTH),
        .DEPTH(rbd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    // ----------------------------------------------------------------
    // Write path staging
    // ----------------------------------------------------------------
    // One staging byte keeps the media data output on a flip-flop.
    assign rx_ready = ce && (state == rbd_pkg::RBD_WR_DATA)
        && (wr_cnt != rbd_pkg::BLOCK_LEN) && (!wr_full || med_wr_ready);
    assign rx_take = rx_valid && rx_ready;
    assign med_wr_valid = ce && wr_full;
    assign wr_pop = med_wr_valid && med_wr_ready;
    assign cmd_ready = ce && (state == rbd_pkg::RBD_IDLE);

    // Bytes go to the media unaltered, header and ECC included.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_full <= 1'b0;
            med_wr_data <= 8'h00;
            med_wr_last <= 1'b0;
        end
        else if (ce)
        begin
            if (rx_take)
            begin
                wr_full <= 1'b1;
                med_wr_data <= rx_data;
                med_wr_last <= (wr_cnt == rbd_pkg::BLOCK_LEN - 16'h0001);
            end
            else if (wr_pop)
            begin
                wr_full <= 1'b0;
                med_wr_last <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            rbd_pkg::RBD_IDLE:
                if (cmd_valid && cmd_ready)
                begin
                    if (cmd_opcode == rbd_pkg::OP_WRITE_FULL
                        && cmd_len != rbd_pkg::BLOCK_LEN)
                        next_state = rbd_pkg::RBD_STATUS;
                    else if (cmd_opcode == rbd_pkg::OP_READ_FULL
                        || cmd_opcode == rbd_pkg::OP_READ_HEADERS
                        || cmd_opcode == rbd_pkg::OP_REFORMAT_TRACK
                        || cmd_opcode == rbd_pkg::OP_WRITE_FULL)
                        next_state = rbd_pkg::RBD_MED_REQ;
                    else
                        next_state = rbd_pkg::RBD_STATUS;
                end
            rbd_pkg::RBD_MED_REQ:
                next_state = (op == rbd_pkg::OP_REFORMAT_TRACK)
                    ? rbd_pkg::RBD_WAIT_DONE : rbd_pkg::RBD_MED_ACK;
            rbd_pkg::RBD_MED_ACK:
                if (med_ack)
                begin
                    if (op == rbd_pkg::OP_READ_HEADERS)
                        next_state = rbd_pkg::RBD_STREAM;
                    else if (!med_prev_ok)
                        next_state = rbd_pkg::RBD_STATUS;
                    else if (op == rbd_pkg::OP_WRITE_FULL)
                        next_state = rbd_pkg::RBD_WR_DATA;
                    else
                        next_state = rbd_pkg::RBD_HDR;
                end
            rbd_pkg::RBD_HDR:
                if (hdr_idx == rbd_pkg::DESC_LEN - 4'h1
                    && (fifo_in_ready || !keep))
                    next_state = rbd_pkg::RBD_STREAM;
            rbd_pkg::RBD_STREAM:
                if (rd_take && med_rd_last)
                    next_state = rbd_pkg::RBD_DRAIN;
            rbd_pkg::RBD_DRAIN:
                if (!tx_valid)
                    next_state = rbd_pkg::RBD_STATUS;
            rbd_pkg::RBD_WR_DATA:
                if (wr_cnt == rbd_pkg::BLOCK_LEN && !wr_full)
                    next_state = rbd_pkg::RBD_WAIT_DONE;
            rbd_pkg::RBD_WAIT_DONE:
                if (med_done)
                    next_state = rbd_pkg::RBD_STATUS;
            rbd_pkg::RBD_STATUS:
                next_state = rbd_pkg::RBD_IDLE;
            default:
                next_state = rbd_pkg::RBD_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            state <= rbd_pkg::RBD_IDLE;
        else if (ce)
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Command capture and media addressing
    // ----------------------------------------------------------------
    // Request fields hold until the next command, so late sampling is safe.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            op <= 8'h00;
            alloc <= rbd_pkg::ZERO_LEN;
            med_op <= rbd_pkg::MOP_READ_BLOCK;
            med_physical_address_flag <= 1'b0;
            med_lba <= 32'h00000000;
            med_cyl <= 16'h0000;
            med_head <= 8'h00;
            med_sector <= 8'h00;
        end
        else if (ce && cmd_valid && cmd_ready)
        begin
            op <= cmd_opcode;
            alloc <= cmd_len;
            med_lba <= cmd_addr;
            med_cyl <= cmd_addr[31:16];
            med_head <= cmd_addr[15:8];
            med_sector <= cmd_addr[7:0];
            med_physical_address_flag <= physical_address_flag;
            case (cmd_opcode)
                rbd_pkg::OP_READ_HEADERS:
                begin
                    med_op <= rbd_pkg::MOP_READ_HEADERS;
                    med_sector <= 8'h00;
                end
                rbd_pkg::OP_REFORMAT_TRACK:
                begin
                    med_op <= rbd_pkg::MOP_FORMAT;
                    med_physical_address_flag <= 1'b1;
                    med_sector <= 8'h00;
                end
                rbd_pkg::OP_WRITE_FULL:
                    med_op <= rbd_pkg::MOP_WRITE_BLOCK;
                default:
                    med_op <= rbd_pkg::MOP_READ_BLOCK;
            endcase
        end
    end

    // Request pulse for one cycle on entry to the media request state.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            med_req <= 1'b0;
        else if (ce)
            med_req <= (next_state == rbd_pkg::RBD_MED_REQ);
    end

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    // Sent count spans header and block, so a tiny allocation cuts the header.
    always_ff @(posedge clk)
    begin
        if (!nrst || (ce && state == rbd_pkg::RBD_IDLE))
        begin
            sent_cnt <= rbd_pkg::ZERO_LEN;
            hdr_idx <= 4'h0;
            wr_cnt <= rbd_pkg::ZERO_LEN;
        end
        else if (ce)
        begin
            if (state == rbd_pkg::RBD_HDR && (fifo_in_ready || !keep))
                hdr_idx <= hdr_idx + 4'h1;
            if (fifo_in_valid && fifo_in_ready)
                sent_cnt <= sent_cnt + 16'h0001;
            if (rx_take)
                wr_cnt <= wr_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    // A failure is latched when seen; the status pulse reports it once.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            fail_check <= 1'b0;
            fail_key <= rbd_pkg::SK_NONE;
        end
        else if (ce)
        begin
            if (state == rbd_pkg::RBD_IDLE && cmd_valid)
            begin
                fail_check <= (next_state == rbd_pkg::RBD_STATUS);
                fail_key <= (next_state == rbd_pkg::RBD_STATUS)
                    ? rbd_pkg::SK_ILLEGAL_REQUEST : rbd_pkg::SK_NONE;
            end
            else if (state == rbd_pkg::RBD_MED_ACK && med_ack
                && next_state == rbd_pkg::RBD_STATUS)
            begin
                fail_check <= 1'b1;
                fail_key <= rbd_pkg::SK_MEDIUM_ERROR;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sts_valid <= 1'b0;
            sts_check <= 1'b0;
            sts_sense_key <= rbd_pkg::SK_NONE;
        end
        else if (ce)
        begin
            sts_valid <= (state == rbd_pkg::RBD_STATUS);
            if (state == rbd_pkg::RBD_STATUS)
            begin
                sts_check <= fail_check;
                sts_sense_key <= fail_key;
            end
        end
    end
endmodule

//--- hw/rbd_fifo.sv
// Byte FIFO that stands between the media read stream and the initiator.
// Assumes the clock enable freezes both pointers and the storage together.
`timescale 1ns/1ns
module rbd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // Handshakes
    // ----------------------------------------------------------------
    // Ready and valid drop while frozen so no byte moves on a dead cycle.
    assign in_ready = ce && (count != (AW+1)'(DEPTH));
    assign out_valid = ce && (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Storage is written only on an accepted byte.
    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

//--- hw/rbd_pkg.sv
// Constants shared by the raw block diagnostic command decoder and its FIFO.
// Assumes one 25 MHz clock and byte-wide data paths on both sides.
package rbd_pkg;
    // ----------------------------------------------------------------
    // Command opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_READ_FULL = 8'hF0;
    localparam logic [7:0] OP_READ_HEADERS = 8'hEE;
    localparam logic [7:0] OP_REFORMAT_TRACK = 8'hED;
    localparam logic [7:0] OP_WRITE_FULL = 8'hFC;

    // ----------------------------------------------------------------
    // Physical block layout
    // ----------------------------------------------------------------
    localparam logic [15:0] HDR_FIELD_LEN = 16'h0006;
    localparam logic [15:0] DATA_FIELD_LEN = 16'h0200;
    localparam logic [15:0] ECC_FIELD_LEN = 16'h0006;
    localparam logic [15:0] BLOCK_LEN = 16'h020C;
    localparam logic [15:0] DESC_REST_LEN = 16'h0008;
    localparam logic [15:0] TOTAL_AVAIL = DESC_REST_LEN + BLOCK_LEN;
    localparam logic [3:0] DESC_LEN = 4'hA;
    localparam logic [2:0] FD_BLOCK_HDR = 3'h1;
    localparam logic [2:0] FD_USER_DATA = 3'h2;
    localparam logic [2:0] FD_ECC = 3'h4;
    localparam logic [2:0] FD_END = 3'h0;

    // ----------------------------------------------------------------
    // Media operations requested from the read/write path
    // ----------------------------------------------------------------
    localparam logic [1:0] MOP_READ_BLOCK = 2'h0;
    localparam logic [1:0] MOP_READ_HEADERS = 2'h1;
    localparam logic [1:0] MOP_FORMAT = 2'h2;
    localparam logic [1:0] MOP_WRITE_BLOCK = 2'h3;

    // ----------------------------------------------------------------
    // Sense keys and FIFO shape
    // ----------------------------------------------------------------
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_MEDIUM_ERROR = 4'h3;
    localparam logic [3:0] SK_ILLEGAL_REQUEST = 4'h5;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [15:0] ZERO_LEN = 16'h0000;

    typedef enum logic [3:0] {
        RBD_IDLE,
        RBD_MED_REQ,
        RBD_MED_ACK,
        RBD_HDR,
        RBD_STREAM,
        RBD_DRAIN,
        RBD_WR_DATA,
        RBD_WAIT_DONE,
        RBD_STATUS
    } rbd_state_t;
endpackage
